// *** src/uirb_map.svh ***
`ifndef UIRB_MAP_SVH
`define UIRB_MAP_SVH

// ****************************************
// Register addresses
// ****************************************
`define UIRB_ADDR_MODE   16'hffa0
`define UIRB_ADDR_STAT   16'hffa1
`define UIRB_ADDR_BRG    16'hffa2
`define UIRB_ADDR_RXBUF  16'hffa3
`define UIRB_ADDR_TXBUF  16'hffa4

// ****************************************
// Mode register fields
// ****************************************
`define UIRB_TXE         7
`define UIRB_RXE         6
`define UIRB_PS_HI       5
`define UIRB_PS_LO       4
`define UIRB_CL          3
`define UIRB_SL          2
`define UIRB_ISRM        1
`define UIRB_IRDA        0

// ****************************************
// Status register fields
// ****************************************
`define UIRB_PE          2
`define UIRB_FE          1
`define UIRB_OVE         0

// ****************************************
// Baud generator fields
// ****************************************
`define UIRB_TPS_HI      6
`define UIRB_TPS_LO      4
`define UIRB_MDL_HI      3
`define UIRB_MDL_LO      0
`define UIRB_BRG_WMASK   8'h7f
`define UIRB_DIV_BASE    5'h10
`define UIRB_IR_BRGC     8'h10

// ****************************************
// Reset values and timing
// ****************************************
`define UIRB_RST_REG     8'h00
`define UIRB_IR_PULSE_N  3
`define UIRB_IR_PULSE_SH 3

`endif

// *** src/uirb_pkg.sv ***
package uirb_pkg;

	// ****************************************
	// Receiver and transmitter states
	// ****************************************
	typedef enum logic [1:0] {
		UIRB_RX_IDLE  = 2'b00,
		UIRB_RX_START = 2'b01,
		UIRB_RX_BITS  = 2'b10
	} uirb_rx_state_t;

	typedef enum logic [0:0] {
		UIRB_TX_IDLE = 1'b0,
		UIRB_TX_SEND = 1'b1
	} uirb_tx_state_t;

	// ****************************************
	// Baud generator state
	// ****************************************
	typedef struct packed {
		logic [6:0] presc;
		logic       ext_prev;
		logic [4:0] cnt;
		logic       src_tick;
		logic       brg_tick;
	} uirb_brg_state_t;

	// ****************************************
	// Top level state
	// ****************************************
	typedef struct packed {
		logic [7:0]     mode;
		logic [7:0]     brgc;
		logic [2:0]     stat;
		logic           rx_full;
		logic [7:0]     rx_buf;
		logic [7:0]     rdata;
		uirb_rx_state_t rx_state;
		logic           rx_half;
		logic [3:0]     rx_cnt;
		logic [8:0]     rx_sh;
		logic           rx_prev;
		logic [5:0]     ir_str;
		logic           irq_err;
		logic           irq_done;
		logic           done_pend;
		uirb_tx_state_t tx_state;
		logic [11:0]    tx_frame;
		logic [3:0]     tx_left;
		logic           tx_half;
		logic [4:0]     pulse_cnt;
		logic           tx_out;
		logic           tx_oe;
		logic           rx_claim;
		logic           tx_irq;
	} uirb_state_t;

endpackage

// *** src/uirb_brg.sv ***
`timescale 1ns/100ps
`include "uirb_map.svh"

module uirb_brg (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       restart,
	input  wire logic [7:0] brgc,
	input  wire logic       ext_baud_clock_pin,
	output logic            src_tick,
	output logic            brg_tick
);

	uirb_pkg::uirb_brg_state_t state_r;
	uirb_pkg::uirb_brg_state_t state_nxt;

	logic [2:0] sel;
	logic [3:0] k;

	// Mask of prescaler bits that must be all ones for a source tick
	function automatic logic [6:0] low_mask(input logic [2:0] n);
		logic [6:0] m;
		m = 7'h00;
		for (int i = 0; i < 7; i++) begin
			if (i < int'(n)) begin
				m[i] = 1'b1;
			end
		end
		return m;
	endfunction

	assign sel = brgc[`UIRB_TPS_HI:`UIRB_TPS_LO];
	assign k   = brgc[`UIRB_MDL_HI:`UIRB_MDL_LO];

	// Prescaler, source select and 5-bit divide counter
	always_comb begin
		logic tick;
		tick = 1'b0;
		state_nxt = state_r;
		state_nxt.presc = state_r.presc + 7'h01;
		state_nxt.ext_prev = ext_baud_clock_pin;
		if (sel == 3'h0) begin
			tick = ext_baud_clock_pin & ~state_r.ext_prev;
		end else begin
			tick = (state_r.presc & low_mask(sel)) == low_mask(sel);
		end
		state_nxt.src_tick = tick;
		state_nxt.brg_tick = 1'b0;
		if (restart) begin
			state_nxt.cnt = 5'h00;
		end else if (tick) begin
			// Prohibited k=15 simply divides by 31; no guard is worth the area
			if (state_r.cnt == `UIRB_DIV_BASE - 5'h01 + {1'b0, k}) begin
				state_nxt.cnt = 5'h00;
				state_nxt.brg_tick = 1'b1;
			end else begin
				state_nxt.cnt = state_r.cnt + 5'h01;
			end
		end
	end

	// State register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign src_tick = state_r.src_tick;
	assign brg_tick = state_r.brg_tick;

endmodule

// *** src/uirb_top.sv ***
`timescale 1ns/100ps
`include "uirb_map.svh"

// Summary of operation
// - Transmit/receive enables pick stop, receive, transmit or both; enabled direction claims pin.
// - Parity field: none, forced zero unchecked, odd, or even.
// - Length bit picks 7 or 8 data bits; stop bit picks one or two stops.
// - Receiver checks only the first stop bit; missing stop sets framing error.
// - Policy bit 1 suppresses receive-complete interrupt on errored frames.
// - Infrared bit switches enabled directions to pulse signalling.
// - Status is read-only: parity bit 2, framing bit 1, overrun bit 0.
// - Overrun set when frame ends with buffer unread; repeats until buffer read.
// - Reset clears mode, status and baud control registers to 00H.
// - Source select 0 uses external clock pin, n uses main clock over 2^n.
// - Divider k gives source clock over 16+k; 15 is prohibited.
// - Falling line waits half a bit, resamples low, restarts counter, samples data.
// - Receive error interrupt comes before receive completion interrupt.
// - Error flags clear on receive buffer read and are replaced each frame.
// - Infrared zero bit is a 3/16 bit-time pulse starting mid-bit.

module uirb_top (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [15:0] bus_addr,
	input  wire logic        bus_wr,
	input  wire logic        bus_rd,
	input  wire logic [7:0]  bus_wdata,
	output logic [7:0]       bus_rdata,
	input  wire logic        serial_in_pin,
	input  wire logic        ext_baud_clock_pin,
	output logic             serial_out_pin,
	output logic             serial_out_oe,
	output logic             rx_pin_claimed,
	output logic             rx_complete_irq,
	output logic             rx_error_irq,
	output logic             tx_complete_irq
);

	uirb_pkg::uirb_state_t state_r;
	uirb_pkg::uirb_state_t state_nxt;

	logic tx_restart;
	logic rx_restart;
	logic tx_src_tick;
	logic tx_brg_tick;
	logic rx_src_tick;
	logic rx_brg_tick;

	// ****************************************
	// Helper functions
	// ****************************************

	// Parity bit for the data; odd selects odd parity
	function automatic logic par_bit(input logic [7:0] d, input logic cl, input logic odd);
		logic x;
		x = ^(cl ? d : {1'b0, d[6:0]});
		return odd ? ~x : x;
	endfunction

	// Number of data bits
	function automatic logic [3:0] data_len(input logic cl);
		return cl ? 4'h8 : 4'h7;
	endfunction

	// ****************************************
	// Baud generators, one per direction so each keeps its own phase
	// ****************************************
	uirb_brg u_tx_brg (
		.ref_clk            (ref_clk),
		.rst                (rst),
		.restart            (tx_restart),
		.brgc               (state_r.brgc),
		.ext_baud_clock_pin (ext_baud_clock_pin),
		.src_tick           (tx_src_tick),
		.brg_tick           (tx_brg_tick)
	);

	uirb_brg u_rx_brg (
		.ref_clk            (ref_clk),
		.rst                (rst),
		.restart            (rx_restart),
		.brgc               (state_r.brgc),
		.ext_baud_clock_pin (ext_baud_clock_pin),
		.src_tick           (rx_src_tick),
		.brg_tick           (rx_brg_tick)
	);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic       txe;
		logic       rxe;
		logic       ir;
		logic       cl;
		logic [1:0] ps;
		logic       rx_lvl;
		logic       wr_mode;
		logic       wr_brg;
		logic       wr_tx;
		logic       rd_buf;
		logic       smp;
		logic [3:0] nd;
		logic [3:0] nbits;
		logic [2:0] flags;
		logic [7:0] d;
		logic [4:0] plen;
		logic [11:0] fr;
		txe = state_r.mode[`UIRB_TXE];
		rxe = state_r.mode[`UIRB_RXE];
		ir = state_r.mode[`UIRB_IRDA];
		cl = state_r.mode[`UIRB_CL];
		ps = state_r.mode[`UIRB_PS_HI:`UIRB_PS_LO];
		nd = data_len(cl);
		nbits = nd + {3'h0, ps != 2'b00};
		wr_mode = bus_wr && bus_addr == `UIRB_ADDR_MODE;
		wr_brg = bus_wr && bus_addr == `UIRB_ADDR_BRG;
		wr_tx = bus_wr && bus_addr == `UIRB_ADDR_TXBUF;
		rd_buf = bus_rd && bus_addr == `UIRB_ADDR_RXBUF;
		smp = 1'b0;
		flags = 3'h0;
		d = 8'h00;
		fr = 12'hfff;
		plen = 5'((`UIRB_IR_PULSE_N * (16 + int'(state_r.brgc[`UIRB_MDL_HI:`UIRB_MDL_LO]))) >> `UIRB_IR_PULSE_SH);
		// Infrared receive: a high pulse means a zero bit held low for one bit
		rx_lvl = ir ? (state_r.ir_str == 6'h00) : serial_in_pin;
		state_nxt = state_r;
		tx_restart = 1'b0;
		rx_restart = 1'b0;
		state_nxt.irq_err = 1'b0;
		state_nxt.irq_done = 1'b0;
		state_nxt.tx_irq = 1'b0;
		state_nxt.rx_prev = rx_lvl;

		// Register writes; mode rewrite is only safe while stopped
		if (wr_mode) begin
			state_nxt.mode = bus_wdata;
		end
		if (wr_brg) begin
			state_nxt.brgc = bus_wdata & `UIRB_BRG_WMASK;
		end

		// Register reads come back one cycle later
		unique case (bus_addr)
			`UIRB_ADDR_MODE:  state_nxt.rdata = state_r.mode;
			`UIRB_ADDR_STAT:  state_nxt.rdata = {5'h00, state_r.stat};
			`UIRB_ADDR_BRG:   state_nxt.rdata = state_r.brgc;
			`UIRB_ADDR_RXBUF: state_nxt.rdata = state_r.rx_buf;
			default:          state_nxt.rdata = 8'h00;
		endcase
		if (!bus_rd) begin
			state_nxt.rdata = state_r.rdata;
		end

		// Buffer read frees the buffer and clears flags; a finishing frame below wins
		if (rd_buf) begin
			state_nxt.rx_full = 1'b0;
			state_nxt.stat = 3'h0;
		end

		// Pin ownership follows the enables
		state_nxt.tx_oe = txe;
		state_nxt.rx_claim = rxe;

		// Infrared pulse stretcher covers one bit time of source ticks
		if (serial_in_pin) begin
			state_nxt.ir_str = 6'({`UIRB_DIV_BASE + {1'b0, state_r.brgc[3:0]}, 1'b0});
		end else if (rx_src_tick && state_r.ir_str != 6'h00) begin
			state_nxt.ir_str = state_r.ir_str - 6'h01;
		end

		// Completion interrupt follows the error interrupt by one cycle
		if (state_r.done_pend) begin
			state_nxt.irq_done = 1'b1;
			state_nxt.done_pend = 1'b0;
		end

		// ****************************************
		// Receiver
		// ****************************************
		if (!rxe) begin
			state_nxt.rx_state = uirb_pkg::UIRB_RX_IDLE;
		end else begin
			unique case (state_r.rx_state)
				uirb_pkg::UIRB_RX_IDLE: begin
					if (!rx_lvl && (state_r.rx_prev || !state_r.rx_claim)) begin
						rx_restart = 1'b1;
						state_nxt.rx_state = uirb_pkg::UIRB_RX_START;
					end
				end
				uirb_pkg::UIRB_RX_START: begin
					if (rx_brg_tick) begin
						if (!rx_lvl) begin
							rx_restart = 1'b1;
							state_nxt.rx_state = uirb_pkg::UIRB_RX_BITS;
							state_nxt.rx_half = 1'b0;
							state_nxt.rx_cnt = 4'h0;
						end else begin
							state_nxt.rx_state = uirb_pkg::UIRB_RX_IDLE;
						end
					end
				end
				uirb_pkg::UIRB_RX_BITS: begin
					if (rx_brg_tick) begin
						state_nxt.rx_half = ~state_r.rx_half;
						smp = state_r.rx_half;
					end
					if (smp && state_r.rx_cnt < nbits) begin
						state_nxt.rx_sh[state_r.rx_cnt] = rx_lvl;
						state_nxt.rx_cnt = state_r.rx_cnt + 4'h1;
					end else if (smp) begin
						// Only the first stop bit is looked at
						d = cl ? state_r.rx_sh[7:0] : {1'b0, state_r.rx_sh[6:0]};
						flags[`UIRB_FE] = ~rx_lvl;
						if (ps[1]) begin
							flags[`UIRB_PE] = par_bit(d, cl, ~ps[0]) != state_r.rx_sh[nd];
						end
						flags[`UIRB_OVE] = state_r.rx_full;
						state_nxt.stat = flags;
						state_nxt.rx_buf = d;
						state_nxt.rx_full = 1'b1;
						state_nxt.irq_err = flags != 3'h0;
						if (!(state_r.mode[`UIRB_ISRM] && flags != 3'h0)) begin
							state_nxt.done_pend = 1'b1;
						end
						state_nxt.rx_state = uirb_pkg::UIRB_RX_IDLE;
					end
				end
				default: begin
					state_nxt.rx_state = uirb_pkg::UIRB_RX_IDLE;
				end
			endcase
		end

		// ****************************************
		// Transmitter
		// ****************************************
		if (!txe) begin
			state_nxt.tx_state = uirb_pkg::UIRB_TX_IDLE;
			state_nxt.tx_out = 1'b1;
			state_nxt.pulse_cnt = 5'h00;
		end else begin
			unique case (state_r.tx_state)
				uirb_pkg::UIRB_TX_IDLE: begin
					state_nxt.tx_out = ~ir;
					if (wr_tx) begin
						// Frame: start, data LSB first, optional parity, stop ones
						fr[0] = 1'b0;
						for (int i = 0; i < 8; i++) begin
							if (i < int'(nd)) begin
								fr[1 + i] = bus_wdata[i];
							end
						end
						if (ps != 2'b00) begin
							fr[nd + 4'h1] = ps[1] & par_bit(bus_wdata, cl, ~ps[0]);
						end
						state_nxt.tx_frame = fr;
						state_nxt.tx_left = nbits + 4'h1 + {3'h0, state_r.mode[`UIRB_SL]};
						state_nxt.tx_half = 1'b0;
						tx_restart = 1'b1;
						state_nxt.tx_state = uirb_pkg::UIRB_TX_SEND;
					end
				end
				uirb_pkg::UIRB_TX_SEND: begin
					if (tx_brg_tick) begin
						state_nxt.tx_half = ~state_r.tx_half;
						if (state_r.tx_half) begin
							state_nxt.tx_frame = {1'b1, state_r.tx_frame[11:1]};
							if (state_r.tx_left == 4'h0) begin
								state_nxt.tx_state = uirb_pkg::UIRB_TX_IDLE;
								state_nxt.tx_irq = 1'b1;
							end else begin
								state_nxt.tx_left = state_r.tx_left - 4'h1;
							end
						end else if (ir && !state_r.tx_frame[0]) begin
							state_nxt.pulse_cnt = plen;
						end
					end else if (tx_src_tick && state_r.pulse_cnt != 5'h00) begin
						state_nxt.pulse_cnt = state_r.pulse_cnt - 5'h01;
					end
					if (ir) begin
						state_nxt.tx_out = state_nxt.pulse_cnt != 5'h00;
					end else begin
						state_nxt.tx_out = state_nxt.tx_frame[0];
					end
				end
				default: begin
					state_nxt.tx_state = uirb_pkg::UIRB_TX_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_r <= '0;
			state_r.tx_out <= 1'b1;
			state_r.rx_prev <= 1'b1;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Outputs straight from flops
	assign bus_rdata       = state_r.rdata;
	assign serial_out_pin  = state_r.tx_out;
	assign serial_out_oe   = state_r.tx_oe;
	assign rx_pin_claimed  = state_r.rx_claim;
	assign rx_complete_irq = state_r.irq_done;
	assign rx_error_irq    = state_r.irq_err;
	assign tx_complete_irq = state_r.tx_irq;

endmodule

// *** dv/uirb_asserts.sv ***
`timescale 1ns/100ps
`include "uirb_map.svh"

// ****************************************
// Port checker
// ****************************************
module uirb_asserts (
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic [15:0] bus_addr,
	input wire logic        bus_wr,
	input wire logic        bus_rd,
	input wire logic [7:0]  bus_wdata,
	input wire logic [7:0]  bus_rdata,
	input wire logic        serial_in_pin,
	input wire logic        ext_baud_clock_pin,
	input wire logic        serial_out_pin,
	input wire logic        serial_out_oe,
	input wire logic        rx_pin_claimed,
	input wire logic        rx_complete_irq,
	input wire logic        rx_error_irq,
	input wire logic        tx_complete_irq
);
	// Pulse width in clocks for the 10H generator setting
	localparam logic [4:0] IR_HI = 5'h0c;
	logic [7:0] mode_r;
	logic [1:0] age_r;
	logic [4:0] hi_r;

	default clocking cb @(posedge ref_clk); endclocking

	// Mode shadow; age lets registered outputs settle after a write
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mode_r <= 8'h00;
			age_r  <= 2'h3;
		end else if (bus_wr && bus_addr == `UIRB_ADDR_MODE) begin
			mode_r <= bus_wdata;
			age_r  <= 2'h0;
		end else if (age_r != 2'h3) begin
			age_r <= age_r + 2'h1;
		end
	end

	// Length of the current high run on the transmit pin, saturating
	always_ff @(posedge ref_clk) begin
		if (rst || !serial_out_pin) begin
			hi_r <= 5'h00;
		end else if (hi_r != 5'h1f) begin
			hi_r <= hi_r + 5'h01;
		end
	end

	AST_RST_CLEAR: assert property (rst |=> bus_rdata == 8'h00 && !serial_out_oe && !rx_pin_claimed)
		else $error("outputs not cleared by reset");
	AST_PIN_CLAIM: assert property (disable iff (rst) age_r == 2'h3 |->
		serial_out_oe == mode_r[`UIRB_TXE] && rx_pin_claimed == mode_r[`UIRB_RXE])
		else $error("pin claim differs from enables");
	AST_ERR_THEN_DONE: assert property (disable iff (rst) rx_error_irq && !mode_r[`UIRB_ISRM] |=> rx_complete_irq)
		else $error("error irq not followed by completion");
	AST_MASKED_DONE: assert property (disable iff (rst) rx_error_irq && mode_r[`UIRB_ISRM] |=> !rx_complete_irq)
		else $error("completion irq on errored frame");
	AST_STAT_HI_ZERO: assert property (disable iff (rst) bus_rd && bus_addr == `UIRB_ADDR_STAT |=> bus_rdata[7:3] == 5'h00)
		else $error("status upper bits not zero");
	AST_BRG_TOP_ZERO: assert property (disable iff (rst) bus_rd && bus_addr == `UIRB_ADDR_BRG |=> !bus_rdata[7])
		else $error("baud control bit 7 set");
	AST_IR_PULSE: assert property (disable iff (rst)
		mode_r[`UIRB_IRDA] && serial_out_oe && age_r == 2'h3 && $fell(serial_out_pin) |-> hi_r == IR_HI)
		else $error("infrared pulse width wrong");
	AST_DONE_NEEDS_RX: assert property (disable iff (rst) rx_complete_irq && age_r == 2'h3 |-> mode_r[`UIRB_RXE])
		else $error("completion irq with receiver off");
	AST_TX_END_HIGH: assert property (disable iff (rst) tx_complete_irq && !mode_r[`UIRB_IRDA] |-> serial_out_pin)
		else $error("line not at stop level at end of frame");
endmodule

bind uirb_top uirb_asserts u_asserts (.ref_clk, .rst, .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata,
	.serial_in_pin, .ext_baud_clock_pin, .serial_out_pin, .serial_out_oe, .rx_pin_claimed,
	.rx_complete_irq, .rx_error_irq, .tx_complete_irq);

// *** dv/uirb_far_end.sv ***
`timescale 1ns/100ps

// ****************************************
// Remote UART on the serial line
// ****************************************
module uirb_far_end (
	input  wire logic ref_clk,
	input  wire logic line_in,
	output logic      line_out
);
	// Idle line is pulled high
	initial begin
		line_out = 1'b1;
	end

	// Send n bits LSB first, t clocks each, then release to idle
	task automatic send(input logic [11:0] f, input int n, input int t);
		@(posedge ref_clk);
		for (int i = 0; i < n; i++) begin
			line_out <= f[i];
			repeat (t) @(posedge ref_clk);
		end
		line_out <= 1'b1;
	endtask

	// Wait for a start edge, then sample every bit centre; a missed start reads as all ones
	task automatic cap(input int n, input int t, output logic [11:0] f);
		f = 12'hfff;
		for (int w = 0; w < 4000 && line_in !== 1'b0; w++) @(posedge ref_clk);
		repeat (t / 2) @(posedge ref_clk);
		for (int i = 0; i < n; i++) begin
			f[i] = line_in;
			repeat (t) @(posedge ref_clk);
		end
	endtask
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/100ps
`include "uirb_map.svh"

module tb_top;
	// Transmit table: mode, baud control and bit time in clocks
	localparam logic [7:0] MODE_T [4] = '{8'h84, 8'h98, 8'ha4, 8'hb8};
	localparam logic [7:0] BRG_T [4]  = '{8'h10, 8'h23, 8'h00, 8'h1e};
	localparam int         BIT_T [4]  = '{64, 152, 192, 120};
	logic        ref_clk   = 1'b0;
	logic        rst       = 1'b1;
	logic [15:0] bus_addr  = 16'h0000;
	logic        bus_wr    = 1'b0;
	logic        bus_rd    = 1'b0;
	logic [7:0]  bus_wdata = 8'h00;
	logic [7:0]  bus_rdata;
	logic        rx_line;
	logic        ext_clk   = 1'b0;
	logic [1:0]  ext_div   = 2'h0;
	logic        tx_pin;
	logic        tx_oe;
	logic        prev_pin  = 1'b1;
	logic        done_irq;
	logic        err_irq;
	logic        txd_irq;
	int          done_n    = 0;
	int          err_n     = 0;
	int          tx_n      = 0;
	int          ir_n      = 0;
	int          cyc       = 0;
	int          error_cnt = 0;
	int          checks    = 0;

	// 200 MHz clock
	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end

	uirb_top DUT (.ref_clk(ref_clk), .rst(rst), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .serial_in_pin(rx_line), .ext_baud_clock_pin(ext_clk),
		.serial_out_pin(tx_pin), .serial_out_oe(tx_oe), .rx_pin_claimed(), .rx_complete_irq(done_irq),
		.rx_error_irq(err_irq), .tx_complete_irq(txd_irq));

	uirb_far_end far (.ref_clk(ref_clk), .line_in(tx_pin), .line_out(rx_line));

	// External baud source of six clocks; irq and pulse counters; hang limit
	always @(posedge ref_clk) begin
		ext_div <= (ext_div == 2'h2) ? 2'h0 : ext_div + 2'h1;
		if (ext_div == 2'h2) ext_clk <= ~ext_clk;
		prev_pin <= tx_pin;
		if (done_irq === 1'b1) done_n++;
		if (err_irq === 1'b1) err_n++;
		if (txd_irq === 1'b1) tx_n++;
		if (tx_oe === 1'b1 && tx_pin === 1'b1 && prev_pin === 1'b0) ir_n++;
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			test_done();
		end
	end

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bus_addr  <= a;
		bus_wdata <= d;
		bus_wr    <= 1'b1;
		@(posedge ref_clk);
		bus_wr <= 1'b0;
	endtask

	// Read and compare one register byte
	task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		bus_addr <= a;
		bus_rd   <= 1'b1;
		@(posedge ref_clk);
		bus_rd <= 1'b0;
		#1;
		chk({4'h0, bus_rdata}, {4'h0, e});
	endtask

	task automatic wait_tx(input int b);
		for (int i = 0; i < 20000 && tx_n == b; i++) @(posedge ref_clk);
		chk(tx_n, b + 1);
	endtask

	// Expected frame for a data byte under a mode setting; n returns the bit count
	function automatic logic [11:0] mk(input logic [7:0] d, input logic [7:0] m, output int n);
		logic [11:0] f;
		logic        p;
		f = 12'hffe;
		n = 1;
		p = ^(d & (m[`UIRB_CL] ? 8'hff : 8'h7f));
		for (int i = 0; i < 7 + m[`UIRB_CL]; i++) begin
			f[n] = d[i];
			n++;
		end
		if (m[`UIRB_PS_HI] | m[`UIRB_PS_LO]) begin
			f[n] = m[`UIRB_PS_HI] & (p ^ ~m[`UIRB_PS_LO]);
			n++;
		end
		n = n + 1 + m[`UIRB_SL];
		return f;
	endfunction

	// Main sequence
	initial begin
		logic [11:0] f;
		logic [11:0] got;
		logic [7:0]  d;
		int          n;
		int          b;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		rdchk(`UIRB_ADDR_MODE, 8'h00);
		rdchk(`UIRB_ADDR_STAT, 8'h00);
		rdchk(`UIRB_ADDR_BRG, 8'h00);
		wr(`UIRB_ADDR_BRG, 8'hff);
		rdchk(`UIRB_ADDR_BRG, 8'h7f);
		wr(`UIRB_ADDR_STAT, 8'hff);
		rdchk(`UIRB_ADDR_STAT, 8'h00);
		rdchk(16'hffa5, 8'h00);
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			wr(`UIRB_ADDR_MODE, 8'h00);
			wr(`UIRB_ADDR_BRG, BRG_T[i]);
			wr(`UIRB_ADDR_MODE, MODE_T[i]);
			rdchk(`UIRB_ADDR_MODE, MODE_T[i]);
			rdchk(`UIRB_ADDR_BRG, BRG_T[i]);
			d = 8'h35 ^ (8'h4c << i);
			f = mk(d, MODE_T[i], n);
			b = tx_n;
			fork
				far.cap(n, BIT_T[i], got);
				wr(`UIRB_ADDR_TXBUF, d);
			join
			chk(got & ~(12'hfff << n), f & ~(12'hfff << n));
			wait_tx(b);
		end
		$display("test transmit done");
		wr(`UIRB_ADDR_MODE, 8'h00);
		wr(`UIRB_ADDR_BRG, 8'h10);
		wr(`UIRB_ADDR_MODE, 8'h7c);
		f = mk(8'ha5, 8'h7c, n);
		far.send(f, n, 64);
		repeat (4) @(posedge ref_clk);
		chk(done_n, 1);
		chk(err_n, 0);
		rdchk(`UIRB_ADDR_STAT, 8'h00);
		rdchk(`UIRB_ADDR_RXBUF, 8'ha5);
		f = mk(8'h3c, 8'h7c, n) ^ 12'h600;
		far.send(f, n, 64);
		repeat (4) @(posedge ref_clk);
		chk(err_n, 1);
		chk(done_n, 2);
		rdchk(`UIRB_ADDR_STAT, 8'h06);
		f = mk(8'h5a, 8'h7c, n);
		far.send(f, n, 64);
		repeat (4) @(posedge ref_clk);
		chk(err_n, 2);
		chk(done_n, 3);
		rdchk(`UIRB_ADDR_STAT, 8'h01);
		rdchk(`UIRB_ADDR_RXBUF, 8'h5a);
		rdchk(`UIRB_ADDR_STAT, 8'h00);
		wr(`UIRB_ADDR_MODE, 8'h00);
		wr(`UIRB_ADDR_MODE, 8'h7e);
		f = mk(8'h3c, 8'h7e, n) ^ 12'h600;
		far.send(f, n, 64);
		repeat (4) @(posedge ref_clk);
		chk(err_n, 3);
		chk(done_n, 3);
		rdchk(`UIRB_ADDR_STAT, 8'h06);
		wr(`UIRB_ADDR_MODE, 8'h00);
		rdchk(`UIRB_ADDR_RXBUF, 8'h3c);
		// Zero parity with seven bits: a flipped parity slot must pass unchecked
		wr(`UIRB_ADDR_MODE, 8'h54);
		f = mk(8'hda, 8'h54, n) ^ 12'h100;
		far.send(f, n, 64);
		repeat (4) @(posedge ref_clk);
		chk(err_n, 3);
		chk(done_n, 4);
		rdchk(`UIRB_ADDR_STAT, 8'h00);
		rdchk(`UIRB_ADDR_RXBUF, 8'h5a);
		$display("test receive done");
		wr(`UIRB_ADDR_MODE, 8'h00);
		wr(`UIRB_ADDR_BRG, `UIRB_IR_BRGC);
		wr(`UIRB_ADDR_MODE, 8'h81);
		b = tx_n;
		n = ir_n;
		wr(`UIRB_ADDR_TXBUF, 8'h0f);
		wait_tx(b);
		chk(ir_n - n, 4);
		$display("test infrared done");
		test_done();
	end
endmodule
